// *** logic/sip_pipe.sv ***
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
//
// Functional notes
// - fetch, dispatch, execute, complete in order
// - fold branches not writing count or link
// - dispatch at most two from bottom slots
// - each dispatch takes one completion entry
// - branch may dispatch alongside two others; here a branch in slot 0 blocks slot 1, so it dispatches alone
// - ready operands read, else rename tag given
// - units capture instruction at dispatch end
// - units write rename, then report finish
// - faulting non-float unit halts until handled
// - exception raised only at oldest entry
// - float unit has three pipelined stages
// - load/store has address and cache stages
// - retire only from lowest two entries
// - exception cancels younger, refetch at vector
// - trace on single-step or traced branch
// - never vector 00E00; 00E10-00EFF reserved
// - perf exception when counter hits limit
// - breakpoint on address, translation, enable match
// - system management interrupt when enabled
// - thermal exception over threshold when enabled
// - reset vector on hard, soft, power-on reset
// - decrementer msb rise raises exception
module sip_pipe #(
	parameter int CQ_DEPTH = sip_pkg::CQ_DEPTH_DEF
) (
	input  wire logic                  pclk,             // Clock
	input  wire logic                  presetn,          // Async reset
	input  wire logic                  psel,             // APB select
	input  wire logic                  penable,          // APB enable
	input  wire logic                  pwrite,           // APB direction
	input  wire logic [7:0]            paddr,            // APB address
	input  wire logic [31:0]           pwdata,           // APB write data
	output logic      [31:0]           prdata,           // APB read data
	output logic                       pready,           // APB ready
	output logic                       pslverr,          // APB error
	input  wire logic                  hard_reset_in,    // Hard reset req
	input  wire logic                  soft_reset_in,    // Soft reset req
	input  wire logic                  system_mgmt_interrupt_in, // Mgmt irq
	input  wire logic                  decrementer_msb,  // Decrementer msb
	input  wire logic                  perf_event,       // Counted event
	input  wire logic [7:0]            junction_temp,    // Sensor value
	input  sip_pkg::sip_inst_type      fetch_a,          // Fetch slot 0
	input  sip_pkg::sip_inst_type      fetch_b,          // Fetch slot 1
	input  wire logic                  fetch_br_upd,     // Branch writes count/link
	input  wire logic [1:0]            src_ready,        // Operands available
	input  sip_pkg::sip_finish_type    int_finish,       // Integer/sys finish
	output logic                       fetch_ready,      // Queue can accept
	output logic      [31:0]           fetch_pc,         // Redirect address
	output logic                       fetch_redirect,   // Redirect strobe
	output logic      [1:0]            disp_valid,       // Slot dispatched
	output logic      [5:0]            disp_tag,         // Completion tags
	output logic      [1:0]            disp_use_tag,     // Operand from tag
	output logic                       disp_branch,      // Branch dispatched
	output logic      [1:0]            retire_valid,     // Retired this cycle
	output logic                       flush,            // Cancel younger
	output logic                       units_halted,     // Non-float halted
	output logic      [2:0]            fpu_busy,         // Float stages busy
	output logic      [1:0]            lsu_busy          // Load/store busy
);
	localparam int CW = $clog2(CQ_DEPTH + 1);

	if (CQ_DEPTH < 2 || CQ_DEPTH > 8) begin : g_bad_depth
		$error("CQ_DEPTH must be 2..8");
	end

	typedef struct packed {
		sip_pkg::sip_state_type st;
		logic [31:0] ctrl;
		logic [31:0] bkpt;
		logic [7:0]  thr_a;
		logic [7:0]  thr_b;
		logic [31:0] perf_lim;
		logic [31:0] perf_cnt;
		logic        msb_q;
		logic [7:0]  pend;
		logic [19:0] last_vec;
		logic [7:0]  cq_v;
		logic [7:0]  cq_done;
		logic [7:0]  cq_exc;
		logic [7:0]  cq_fp;
		logic [7:0]  cq_br;
		logic [255:0] cq_pc;
		logic [2:0]  head;
		logic [2:0]  tail;
		logic [CW-1:0] cnt;
		logic [2:0]  fp_pipe;
		logic [8:0]  fp_tag;
		logic [1:0]  ls_pipe;
		logic [5:0]  ls_tag;
		logic        halted;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        fetch_ready;
		logic [31:0] fetch_pc;
		logic        fetch_redirect;
		logic [1:0]  disp_valid;
		logic [5:0]  disp_tag;
		logic [1:0]  disp_use_tag;
		logic        disp_branch;
		logic [1:0]  retire_valid;
		logic        flush;
	} state_type;

	state_type s_reg;
	state_type s_next;

	function automatic logic [2:0] wrap(input logic [2:0] p, input int n);
		int v;
		v = (int'(p) + n) % CQ_DEPTH;
		return 3'(v);
	endfunction : wrap

	// Fixed priority among latched requests
	function automatic logic [19:0] pend_vec(input logic [3:0] p);
		if (p[1])
			return sip_pkg::VEC_MGMT;
		else if (p[3])
			return sip_pkg::VEC_DECR;
		else if (p[2])
			return sip_pkg::VEC_THERM;
		return sip_pkg::VEC_PERF;
	endfunction : pend_vec

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic        acc;
		logic        rd_hit;
		logic [1:0]  want;
		logic [1:0]  go;
		logic [2:0]  pos;
		logic [2:0]  ret_n;
		logic [2:0]  disp_n;
		logic        exc_now;
		logic [19:0] vec;
		logic [31:0] opc;
		logic        trace_hit;
		logic        bkpt_hit;
		logic        therm;
		logic [3:0]  pset;
		s_next = s_reg;
		acc = psel && penable && !s_reg.pready;
		rd_hit = 1'b1;
		go = 2'b00;
		ret_n = 3'd0;
		disp_n = 3'd0;
		exc_now = 1'b0;
		vec = 20'h00000;
		trace_hit = 1'b0;
		bkpt_hit = 1'b0;
		want = 2'b00;
		pos = 3'd0;
		opc = 32'h0000_0000;
		therm = 1'b0;
		pset = 4'h0;
		s_next.pready = acc;
		s_next.pslverr = 1'b0;
		s_next.fetch_redirect = 1'b0;
		s_next.flush = 1'b0;
		s_next.disp_valid = 2'b00;
		s_next.disp_use_tag = 2'b00;
		s_next.disp_branch = 1'b0;
		s_next.retire_valid = 2'b00;

		// Register access; one wait state, unmapped address errors
		if (acc) begin
			s_next.prdata = 32'h0000_0000;
			case (paddr)
			sip_pkg::OFS_CTRL:     s_next.prdata = s_reg.ctrl;
			sip_pkg::OFS_BKPT:     s_next.prdata = s_reg.bkpt;
			sip_pkg::OFS_THR_A:    s_next.prdata = {24'h0, s_reg.thr_a};
			sip_pkg::OFS_THR_B:    s_next.prdata = {24'h0, s_reg.thr_b};
			sip_pkg::OFS_PERF_LIM: s_next.prdata = s_reg.perf_lim;
			sip_pkg::OFS_PERF_CNT: s_next.prdata = s_reg.perf_cnt;
			sip_pkg::OFS_STATUS:   s_next.prdata = {24'h0, s_reg.pend};
			sip_pkg::OFS_VECTOR:   s_next.prdata = {12'h0, s_reg.last_vec};
			default:               rd_hit = 1'b0;
			endcase
			s_next.pslverr = !rd_hit;
			if (pwrite && rd_hit) begin
				case (paddr)
				sip_pkg::OFS_CTRL:     s_next.ctrl = pwdata;
				sip_pkg::OFS_BKPT:     s_next.bkpt = pwdata;
				sip_pkg::OFS_THR_A:    s_next.thr_a = pwdata[7:0];
				sip_pkg::OFS_THR_B:    s_next.thr_b = pwdata[7:0];
				sip_pkg::OFS_PERF_LIM: s_next.perf_lim = pwdata;
				sip_pkg::OFS_PERF_CNT: s_next.perf_cnt = pwdata;
				// Write one to clear pending asynchronous requests
				sip_pkg::OFS_STATUS:   s_next.pend = s_reg.pend & ~pwdata[7:0];
				default:               s_next.pend = s_reg.pend;
				endcase
			end
		end

		// Asynchronous sources latch as pending; set wins over clear
		if (perf_event)
			s_next.perf_cnt = s_reg.perf_cnt + 32'h1;
		if (s_reg.perf_cnt == s_reg.perf_lim && s_reg.perf_lim != 32'h0
		    && s_reg.ctrl[sip_pkg::CTL_PMIE])
			pset[0] = 1'b1;
		if (system_mgmt_interrupt_in && s_reg.ctrl[sip_pkg::CTL_EE])
			pset[1] = 1'b1;
		therm = s_reg.ctrl[sip_pkg::CTL_THEN] &&
		        (junction_temp > s_reg.thr_a || junction_temp > s_reg.thr_b);
		if (therm && s_reg.ctrl[sip_pkg::CTL_EE])
			pset[2] = 1'b1;
		s_next.msb_q = decrementer_msb;
		if (decrementer_msb && !s_reg.msb_q && s_reg.ctrl[sip_pkg::CTL_EE])
			pset[3] = 1'b1;

		////////////////////////////////////////////////////////////////////
		case (s_reg.st)
		sip_pkg::ST_RESET_VEC: begin
			s_next.fetch_pc = {12'h0, sip_pkg::VEC_RESET};
			s_next.fetch_redirect = 1'b1;
			s_next.last_vec = sip_pkg::VEC_RESET;
			s_next.st = sip_pkg::ST_RUN;
		end
		sip_pkg::ST_RUN: begin
			// Finish reports from units
			if (int_finish.valid) begin
				s_next.cq_done[int_finish.tag] = 1'b1;
				s_next.cq_exc[int_finish.tag] = int_finish.exc;
				if (int_finish.exc)
					s_next.halted = 1'b1;
			end
			// Float and load/store pipes advance one stage per cycle
			s_next.fp_pipe = {s_reg.fp_pipe[1:0], 1'b0};
			s_next.fp_tag = {s_reg.fp_tag[5:0], 3'd0};
			if (s_reg.fp_pipe[2])
				s_next.cq_done[s_reg.fp_tag[8:6]] = 1'b1;
			s_next.ls_pipe = {s_reg.ls_pipe[0], 1'b0};
			s_next.ls_tag = {s_reg.ls_tag[2:0], 3'd0};
			if (s_reg.ls_pipe[1])
				s_next.cq_done[s_reg.ls_tag[5:3]] = 1'b1;

			// Completion from the oldest two entries only
			for (int i = 0; i < sip_pkg::RET_SLOTS; i++) begin
				pos = wrap(s_reg.head, i);
				if (!exc_now && ret_n == 3'(i) && s_reg.cq_v[pos] &&
				    s_reg.cq_done[pos]) begin
					opc = s_reg.cq_pc[pos*32 +: 32];
					trace_hit = s_reg.ctrl[sip_pkg::CTL_SE] ||
					            (s_reg.cq_br[pos] &&
					             s_reg.ctrl[sip_pkg::CTL_BE]);
					bkpt_hit = s_reg.bkpt[sip_pkg::BKP_EN] &&
					           s_reg.bkpt[31:2] == opc[31:2] &&
					           s_reg.bkpt[sip_pkg::BKP_TE] ==
					           s_reg.ctrl[sip_pkg::CTL_IR];
					// Fixed priority; 00E00 is never chosen
					if (s_reg.cq_exc[pos]) begin
						exc_now = 1'b1;
						vec = sip_pkg::VEC_FPASSIST + 20'h00100;
					end else if (bkpt_hit) begin
						exc_now = 1'b1;
						vec = sip_pkg::VEC_BKPT;
					end else if (s_reg.pend[3:0] != 4'h0) begin
						exc_now = 1'b1;
						vec = pend_vec(s_reg.pend[3:0]);
					end else begin
						s_next.retire_valid[i] = 1'b1;
						s_next.cq_v[pos] = 1'b0;
						ret_n = ret_n + 3'd1;
						if (trace_hit) begin
							exc_now = 1'b1;
							vec = sip_pkg::VEC_TRACE;
						end
					end
				end
			end
			// Nothing left to complete: a latched request is taken at once
			if (!exc_now && s_reg.cnt == '0 && s_reg.pend[3:0] != 4'h0) begin
				exc_now = 1'b1;
				vec = pend_vec(s_reg.pend[3:0]);
			end

			if (exc_now) begin
				s_next.cq_v = 8'h00;
				s_next.fp_pipe = 3'b000;
				s_next.ls_pipe = 2'b00;
				s_next.flush = 1'b1;
				s_next.fetch_redirect = 1'b1;
				s_next.fetch_pc = {12'h0, vec};
				s_next.last_vec = vec;
				if (vec == sip_pkg::VEC_MGMT)
					s_next.pend[1] = 1'b0;
				if (vec == sip_pkg::VEC_DECR)
					s_next.pend[3] = 1'b0;
				if (vec == sip_pkg::VEC_THERM)
					s_next.pend[2] = 1'b0;
				if (vec == sip_pkg::VEC_PERF)
					s_next.pend[0] = 1'b0;
				s_next.st = sip_pkg::ST_FLUSH;
			end else begin
				s_next.head = wrap(s_reg.head, int'(ret_n));
				// Dispatch two in order into free entries
				want = {fetch_b.valid && !fetch_b.is_branch,
				        fetch_a.valid && !fetch_a.is_branch};
				for (int j = 0; j < sip_pkg::DISP_SLOTS; j++) begin
					pos = wrap(s_reg.tail, int'(disp_n));
					if (want[j] && (j == 0 || go[0]) && !s_reg.halted &&
					    int'(s_reg.cnt) + int'(disp_n) < CQ_DEPTH) begin
						go[j] = 1'b1;
						disp_n = disp_n + 3'd1;
						s_next.cq_v[pos] = 1'b1;
						s_next.cq_done[pos] = 1'b0;
						s_next.cq_exc[pos] = 1'b0;
						s_next.cq_br[pos] = 1'b0;
						s_next.cq_pc[pos*32 +: 32] = j == 0 ? fetch_a.pc
						                                     : fetch_b.pc;
						s_next.disp_valid[j] = 1'b1;
						s_next.disp_tag[j*3 +: 3] = pos;
						s_next.disp_use_tag[j] = !src_ready[j];
						if (j == 0 ? fetch_a.is_fp : fetch_b.is_fp) begin
							s_next.fp_pipe[0] = 1'b1;
							s_next.fp_tag[2:0] = pos;
						end else if (j == 0 ? fetch_a.is_ls
						                    : fetch_b.is_ls) begin
							s_next.ls_pipe[0] = 1'b1;
							s_next.ls_tag[2:0] = pos;
						end
					end
				end
				// Branch from slot 0 only, dispatched alone; folded unless it updates count/link
				if (fetch_a.valid && fetch_a.is_branch && !s_reg.halted) begin
					if (fetch_br_upd && int'(s_reg.cnt) + int'(disp_n)
					    < CQ_DEPTH) begin
						s_next.disp_branch = 1'b1;
						pos = wrap(s_reg.tail, int'(disp_n));
						disp_n = disp_n + 3'd1;
						s_next.cq_v[pos] = 1'b1;
						s_next.cq_done[pos] = 1'b1;
						s_next.cq_exc[pos] = 1'b0;
						s_next.cq_br[pos] = 1'b1;
						s_next.cq_pc[pos*32 +: 32] = fetch_a.pc;
					end
				end
				s_next.tail = wrap(s_reg.tail, int'(disp_n));
				s_next.cnt = CW'(int'(s_reg.cnt) - int'(ret_n) + int'(disp_n));
			end
		end
		sip_pkg::ST_FLUSH: begin
			s_next.head = 3'd0;
			s_next.tail = 3'd0;
			s_next.cnt = '0;
			s_next.halted = 1'b0;
			s_next.st = sip_pkg::ST_RUN;
		end
		default: s_next.st = sip_pkg::ST_RUN;
		endcase
		// A new request in the cycle its predecessor is taken must not be lost
		s_next.pend[3:0] = s_next.pend[3:0] | pset;
		s_next.fetch_ready = s_next.st == sip_pkg::ST_RUN && !s_next.halted &&
		                     int'(s_next.cnt) + 2 <= CQ_DEPTH;
		if (hard_reset_in || soft_reset_in)
			s_next.st = sip_pkg::ST_RESET_VEC;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.st <= sip_pkg::ST_RESET_VEC;
			s_reg.ctrl <= sip_pkg::CTRL_RST;
			s_reg.fetch_pc <= sip_pkg::RESET_PC;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata         = s_reg.prdata;
	assign pready         = s_reg.pready;
	assign pslverr        = s_reg.pslverr;
	assign fetch_ready    = s_reg.fetch_ready;
	assign fetch_pc       = s_reg.fetch_pc;
	assign fetch_redirect = s_reg.fetch_redirect;
	assign disp_valid     = s_reg.disp_valid;
	assign disp_tag       = s_reg.disp_tag;
	assign disp_use_tag   = s_reg.disp_use_tag;
	assign disp_branch    = s_reg.disp_branch;
	assign retire_valid   = s_reg.retire_valid;
	assign flush          = s_reg.flush;
	assign units_halted   = s_reg.halted;
	assign fpu_busy       = s_reg.fp_pipe;
	assign lsu_busy       = s_reg.ls_pipe;
endmodule : sip_pipe

// *** logic/sip_pkg.sv ***
package sip_pkg;
	localparam int ADDR_W = 32;
	localparam int TAG_W  = 3;
	localparam int CQ_DEPTH_DEF = 6;
	localparam int DISP_SLOTS   = 2;
	localparam int RET_SLOTS    = 2;
	localparam int FPU_STAGES   = 3;
	localparam int LSU_STAGES   = 2;
	// Exception vector offsets
	localparam logic [19:0] VEC_RESET   = 20'h00100;
	localparam logic [19:0] VEC_DECR    = 20'h00900;
	localparam logic [19:0] VEC_TRACE   = 20'h00d00;
	localparam logic [19:0] VEC_FPASSIST = 20'h00e00;
	localparam logic [19:0] VEC_PERF    = 20'h00f00;
	localparam logic [19:0] VEC_BKPT    = 20'h01300;
	localparam logic [19:0] VEC_MGMT    = 20'h01400;
	localparam logic [19:0] VEC_THERM   = 20'h01700;
	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_BKPT     = 8'h04;
	localparam logic [7:0] OFS_THR_A    = 8'h08;
	localparam logic [7:0] OFS_THR_B    = 8'h0c;
	localparam logic [7:0] OFS_PERF_LIM = 8'h10;
	localparam logic [7:0] OFS_PERF_CNT = 8'h14;
	localparam logic [7:0] OFS_STATUS   = 8'h18;
	localparam logic [7:0] OFS_VECTOR   = 8'h1c;
	// Control register bit positions
	localparam int CTL_SE   = 0;
	localparam int CTL_BE   = 1;
	localparam int CTL_EE   = 2;
	localparam int CTL_IR   = 3;
	localparam int CTL_PMIE = 4;
	localparam int CTL_THEN = 5;
	// Breakpoint register bit positions (bits 31:2 compare address)
	localparam int BKP_EN = 0;
	localparam int BKP_TE = 1;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] RESET_PC = 32'h0000_0100;

	typedef enum {
		ST_RESET_VEC,
		ST_RUN,
		ST_FLUSH
	} sip_state_type;

	typedef struct packed {
		logic              valid;
		logic              is_fp;
		logic              is_ls;
		logic              is_branch;
		logic [ADDR_W-1:0] pc;
	} sip_inst_type;

	typedef struct packed {
		logic             valid;
		logic [TAG_W-1:0] tag;
		logic             exc;
	} sip_finish_type;
endpackage : sip_pkg

// *** tb/sip_far_end.sv ***
`timescale 1ns/100ps
module sip_far_end (
	input  wire logic               pclk,         // Clock
	input  wire logic               presetn,      // Reset
	input  wire logic               run,          // Offer code
	input  wire logic [1:0]         kind,         // 0 int 1 fp 2 ls 3 br
	input  wire logic               br_upd,       // Branch keeps
	input  wire logic               slow,         // Hold finishes
	input  wire logic               exc_req,      // Finishes fault
	input  wire logic [31:0]        pc_base,      // Start pc
	input  wire logic               fetch_ready,  // Room
	input  wire logic               flush,        // Cancel
	input  wire logic [1:0]         disp_valid,   // Dispatched
	input  wire logic [5:0]         disp_tag,     // Their tags
	output sip_pkg::sip_inst_type   fetch_a,      // Slot 0
	output sip_pkg::sip_inst_type   fetch_b,      // Slot 1
	output logic                    fetch_br_upd, // Branch writes
	output logic [1:0]              src_ready,    // Operands
	output sip_pkg::sip_finish_type int_finish    // Unit finish
);
	logic [31:0]               pc;
	logic [sip_pkg::TAG_W-1:0] tags[$];
	////////////////////////////////////////
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_a <= '0;
			fetch_b <= '0;
			int_finish <= '0;
			fetch_br_upd <= 1'b0;
			src_ready <= 2'b01;
			pc = 32'h0;
			tags.delete();
		end else begin
			// Idle slots drive valid and the kind bits low so stale words never look valid
			fetch_a <= {1'b0, 3'b000, ~pc};
			fetch_b <= {1'b0, 3'b000, pc};
			fetch_br_upd <= br_upd;
			if (!run)
				pc = pc_base;
			else if (fetch_ready) begin
				fetch_a <= '{1'b1, kind == 2'd1, kind == 2'd2, kind == 2'd3, pc};
				fetch_b <= '{kind == 2'd0, 1'b0, 1'b0, 1'b0, pc + 32'h4};
				src_ready <= ~src_ready;
				pc = pc + 32'h8;
			end
			if (flush)
				tags.delete();
			else if (kind == 2'd0)
				for (int i = 0; i < 2; i++)
					if (disp_valid[i])
						tags.push_back(disp_tag[i*3 +: 3]);
			int_finish <= '0;
			if (!slow && tags.size() > 0)
				int_finish <= '{1'b1, tags.pop_front(), exc_req};
		end
	end
endmodule : sip_far_end

// *** tb/sip_pipe_properties.sv ***
`timescale 1ns/100ps
module sip_pipe_properties #(
	parameter int CQ_DEPTH = sip_pkg::CQ_DEPTH_DEF
) (
	input wire logic        pclk,                     // Clock
	input wire logic        presetn,                  // Reset
	input wire logic        psel,                     // Select
	input wire logic        penable,                  // Enable
	input wire logic        pwrite,                   // Write
	input wire logic [7:0]  paddr,                    // Address
	input wire logic [31:0] pwdata,                   // Write data
	input wire logic        pready,                   // Ready
	input wire logic        system_mgmt_interrupt_in, // Mgmt irq
	input wire logic [1:0]  src_ready,                // Operands
	input wire logic [31:0] fetch_pc,                 // Redirect pc
	input wire logic        fetch_redirect,           // Redirect
	input wire logic [1:0]  disp_valid,               // Dispatch
	input wire logic [1:0]  disp_use_tag,             // Tagged operand
	input wire logic        disp_branch,              // Branch kept
	input wire logic [1:0]  retire_valid,             // Retire
	input wire logic        flush,                    // Flush
	input wire logic [2:0]  fpu_busy,                 // Float stages
	input wire logic [1:0]  lsu_busy                  // Load/store
);
	typedef struct packed {
		logic       ee;
		logic [3:0] occ;
	} sip_chk_type;
	sip_chk_type st_reg;
	sip_chk_type st_next;
	////////////////////////////////////////
	// Enable seen one cycle after the design takes the write; harmless
	always_comb begin
		st_next = st_reg;
		st_next.occ = st_reg.occ + 4'(disp_valid[0]) + 4'(disp_valid[1])
			+ 4'(disp_branch) - 4'(retire_valid[0]) - 4'(retire_valid[1]);
		if (flush)
			st_next.occ = 4'h0;
		if (psel && penable && pready && pwrite && paddr == 8'h00)
			st_next.ee = pwdata[sip_pkg::CTL_EE];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	a_reset_vec: assert property ($rose(presetn) |=>
		fetch_redirect && fetch_pc == 32'h0000_0100)
		else $error("no reset redirect");
	a_disp_pair: assert property (disp_valid[1] |-> disp_valid[0])
		else $error("slot b without slot a");
	a_retire_pair: assert property (retire_valid[1] |-> retire_valid[0])
		else $error("retire out of order");
	a_queue_bound: assert property (st_reg.occ <= 4'(CQ_DEPTH))
		else $error("queue overfilled");
	a_operand_tag: assert property (disp_valid[0] |->
		disp_use_tag[0] == !$past(src_ready[0]))
		else $error("operand tag wrong");
	a_fpu_stages: assert property (fpu_busy[0] |=> fpu_busy[1] ##1 fpu_busy[2])
		else $error("float stage skipped");
	a_lsu_stages: assert property (lsu_busy[0] |=> lsu_busy[1])
		else $error("load/store stage skipped");
	a_flush_redir: assert property (flush |-> fetch_redirect)
		else $error("flush without redirect");
	a_no_reserved: assert property (fetch_redirect |->
		!(fetch_pc inside {[32'h0000_0e00:32'h0000_0eff]}))
		else $error("reserved vector");
	a_mgmt_taken: assert property ($rose(st_reg.ee) &&
		system_mgmt_interrupt_in |-> ##[1:20]
		fetch_redirect && fetch_pc == 32'h0000_1400)
		else $error("mgmt interrupt missed");
	c_flush: cover property (flush);
	c_pair: cover property (disp_valid == 2'b11);
	c_retire2: cover property (retire_valid == 2'b11);
endmodule : sip_pipe_properties

bind sip_pipe sip_pipe_properties #(.CQ_DEPTH(CQ_DEPTH)) u_props (.*);

// *** tb/tb.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("wrong value at %0t: %h, expected %h", $time, g, e); end end
module tb;
	localparam int CQ = 6;
	logic                    pclk, presetn, psel, penable, pwrite, err, fl;
	logic                    pready, pslverr, hard_reset_in, soft_reset_in;
	logic                    system_mgmt_interrupt_in, decrementer_msb;
	logic                    perf_event, fetch_br_upd, fetch_ready, flush;
	logic                    fetch_redirect, disp_branch, units_halted;
	logic                    run, br_upd, slow, exc_req, fp_seen, ls_seen;
	logic                    pair_seen, halt_seen;
	logic [1:0]              src_ready, disp_valid, disp_use_tag, kind;
	logic [1:0]              retire_valid, lsu_busy;
	logic [2:0]              fpu_busy;
	logic [5:0]              disp_tag;
	logic [7:0]              paddr, junction_temp;
	logic [31:0]             pwdata, prdata, fetch_pc, pc_base, rd;
	sip_pkg::sip_inst_type   fetch_a, fetch_b;
	sip_pkg::sip_finish_type int_finish;
	int                      fails, check_count, n_disp, n_ret, n_br, m, b0;
	sip_pipe #(.CQ_DEPTH(CQ)) dut (.*);
	sip_far_end far (.*);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		n_disp += int'(disp_valid[0]) + int'(disp_valid[1]);
		n_ret += int'(retire_valid[0]) + int'(retire_valid[1]);
		n_br += int'(disp_branch);
		pair_seen |= disp_valid == 2'b11;
		fp_seen |= fpu_busy[2];
		ls_seen |= lsu_busy[1];
		halt_seen |= units_halted;
	end
	////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rdchk
	task automatic issue(input logic [1:0] k);
		kind <= k;
		@(posedge pclk);
		run <= 1'b1;
		@(posedge pclk);
		run <= 1'b0;
		repeat (12) @(posedge pclk);
	endtask : issue
	task automatic wait_vec(input logic [31:0] v);
		m = 0;
		do begin
			@(posedge pclk);
			m++;
		end while (fetch_redirect !== 1'b1 && m < 60);
		fl = flush;
		`CHK(fetch_pc, v)
	endtask : wait_vec
	task automatic no_vec();
		m = 0;
		repeat (30) begin
			@(posedge pclk);
			m += int'(fetch_redirect === 1'b1);
		end
		`CHK(m, 0)
	endtask : no_vec
	task automatic trig(input logic [31:0] c, input logic [31:0] v);
		fork
			wait_vec(v);
			wr(sip_pkg::OFS_CTRL, c);
		join
	endtask : trig
	task automatic quiet();
		wr(sip_pkg::OFS_CTRL, 32'h0);
		wr(sip_pkg::OFS_STATUS, 32'hf);
		repeat (4) @(posedge pclk);
	endtask : quiet
	task automatic test_done();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, hard_reset_in, soft_reset_in} = '0;
		{system_mgmt_interrupt_in, decrementer_msb, perf_event, run} = '0;
		{br_upd, slow, exc_req, kind, paddr, pwdata, junction_temp} = '0;
		{pair_seen, fp_seen, ls_seen, halt_seen} = '0;
		pc_base = 32'h0000_3000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		wait_vec(32'h0000_0100);
		rdchk(sip_pkg::OFS_CTRL, sip_pkg::CTRL_RST);
		apb(1'b0, 8'h20, 32'h0);
		`CHK(err, 1'b1)
		wr(sip_pkg::OFS_THR_A, 32'h50);
		wr(sip_pkg::OFS_THR_B, 32'hff);
		rdchk(sip_pkg::OFS_THR_A, 32'h50);
		// Finishes held back so only the queue limit stops dispatch
		slow <= 1'b1;
		run <= 1'b1;
		repeat (40) @(posedge pclk);
		`CHK(n_disp, CQ)
		`CHK(fetch_ready, 1'b0)
		slow <= 1'b0;
		repeat (40) @(posedge pclk);
		run <= 1'b0;
		repeat (30) @(posedge pclk);
		`CHK(n_ret, n_disp)
		`CHK(pair_seen, 1'b1)
		issue(2'd1);
		issue(2'd2);
		`CHK({fp_seen, ls_seen}, 2'b11)
		b0 = n_br;
		issue(2'd3);
		`CHK(n_br - b0, 0)
		br_upd <= 1'b1;
		issue(2'd3);
		`CHK(n_br - b0, 1)
		wr(sip_pkg::OFS_CTRL, 32'h2);
		fork
			wait_vec(32'h0000_0d00);
			issue(2'd3);
		join
		quiet();
		br_upd <= 1'b0;
		wr(sip_pkg::OFS_CTRL, 32'h1);
		fork
			wait_vec(32'h0000_0d00);
			issue(2'd0);
		join
		quiet();
		wr(sip_pkg::OFS_BKPT, 32'h0000_3003);
		fork
			no_vec();
			issue(2'd0);
		join
		wr(sip_pkg::OFS_BKPT, 32'h0000_3001);
		fork
			wait_vec(32'h0000_1300);
			issue(2'd0);
		join
		wr(sip_pkg::OFS_BKPT, 32'h0);
		quiet();
		system_mgmt_interrupt_in <= 1'b1;
		no_vec();
		trig(32'h4, 32'h0000_1400);
		system_mgmt_interrupt_in <= 1'b0;
		rdchk(sip_pkg::OFS_VECTOR, 32'h0000_1400);
		quiet();
		wr(sip_pkg::OFS_CTRL, 32'h4);
		decrementer_msb <= 1'b1;
		wait_vec(32'h0000_0900);
		decrementer_msb <= 1'b0;
		quiet();
		junction_temp <= 8'h60;
		trig(32'h24, 32'h0000_1700);
		junction_temp <= 8'h00;
		quiet();
		wr(sip_pkg::OFS_PERF_LIM, 32'h3);
		wr(sip_pkg::OFS_CTRL, 32'h10);
		perf_event <= 1'b1;
		fork
			wait_vec(32'h0000_0f00);
			begin
				repeat (3) @(posedge pclk);
				perf_event <= 1'b0;
			end
		join
		wr(sip_pkg::OFS_PERF_LIM, 32'h0);
		quiet();
		exc_req <= 1'b1;
		fork
			wait_vec(32'h0000_0f00);
			issue(2'd0);
		join
		`CHK(fl, 1'b1)
		`CHK(halt_seen, 1'b1)
		exc_req <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			{soft_reset_in, hard_reset_in} <= 2'(i + 1);
			wait_vec(32'h0000_0100);
			{soft_reset_in, hard_reset_in} <= 2'b00;
			repeat (6) @(posedge pclk);
		end
		test_done();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		test_done();
	end
endmodule : tb
